// File: rtl/i2c_req_pkg.sv
// package: constants and carriers for the request and interrupt logic
package i2c_req_pkg;

   // ----------------------------------------------------------------
   // interrupt sources
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 6;

   // bit positions inside the flag and enable vectors
   localparam int BIT_DATA_READY = 0;
   localparam int BIT_ADDRESS_MATCH = 1;
   localparam int BIT_STOP_RECEIVED = 2;
   localparam int BIT_ERROR = 3;
   localparam int BIT_TARGET_BUS = 4;
   localparam int BIT_CONTROLLER_BUS = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [NUM_SRC-1:0] FLAG_RST = 6'h00;
   localparam logic [NUM_SRC-1:0] ENABLE_RST = 6'h00;
   localparam logic REQ_RST = 1'b0;
   localparam logic EVENT_RST = 1'b0;

   // field order matches the bit positions above, msb first
   typedef struct packed {
      logic controller_side_bus_flag;
      logic target_side_bus_flag;
      logic error_flag;
      logic stop_received_flag;
      logic address_match_flag;
      logic data_ready_flag;
   } irq_src_t;

   // pulses from the two-wire bus engine plus the ctrl_side level, same clock
   typedef struct packed {
      logic data_ready;
      logic address_match;
      logic stop_received;
      logic error;
      logic addr_acked;
      logic byte_done;
      logic ctrl_side;
   } bus_event_t;

   // data register traffic and target mode, same clock
   typedef struct packed {
      logic target_tx_mode;
      logic target_rx_mode;
      logic tx_data_needed;
      logic rx_data_received;
      logic data_reg_written;
      logic data_reg_read;
   } dma_event_t;

   // one software write: strobe plus bit pattern
   typedef struct packed {
      logic wr;
      irq_src_t data;
   } reg_write_t;

endpackage

// File: rtl/irq_source_cell.sv
// one interrupt source: sticky flag and its enable bit
`timescale 1ns/10ps
`default_nettype none

module irq_source_cell
   import i2c_req_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic soft_clr,
   input wire logic set_evt,
   input wire logic clr_flag,
   input wire logic en_set,
   input wire logic en_clr,
   output logic flag_q,
   output logic enable_q
);

   // ----------------------------------------------------------------
   // flag: hardware set wins over a clear in the same cycle
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || soft_clr)
      begin
         flag_q <= 1'b0;
      end
      else if (set_evt)
      begin
         flag_q <= 1'b1;
      end
      else if (clr_flag)
      begin
         flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // enable: set wins when set and clear arrive together
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || soft_clr)
      begin
         enable_q <= 1'b0;
      end
      else if (en_set)
      begin
         enable_q <= 1'b1;
      end
      else if (en_clr)
      begin
         enable_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// File: rtl/i2c_req_irq.sv
// request and interrupt logic of the two-wire bus interface
//
// Contract
// - quick command runs only while quick_cmd_enable is set; else data phase follows.
// - quick command sets the side's bus flag right after address acknowledge.
// - each source has its own flag, set by its own condition.
// - writing one to an enable-set bit enables that source; zeros do nothing.
// - writing one to an enable-clear bit disables that source; zeros do nothing.
// - interrupt request is high while any flag and its enable are set.
// - request stays until flag cleared, source disabled, or interface reset.
// - target transmit: dma request when data needed, dropped on data write.
// - target receive: dma request on data received, dropped on data read.
// - no event outputs in target mode; only dma and interrupts.
`timescale 1ns/10ps
`default_nettype none

module i2c_req_irq
   import i2c_req_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic iface_reset,
   input wire logic quick_cmd_enable,
   input wire bus_event_t bus_evt,
   input wire dma_event_t dma_evt,
   input wire reg_write_t flag_clear_wr,
   input wire reg_write_t enable_set_wr,
   input wire reg_write_t enable_clear_wr,
   output wire irq_src_t irq_flag_reg,
   output wire irq_src_t irq_enable_reg,
   output logic irq_request_q,
   output logic dma_tx_request_q,
   output logic dma_rx_request_q,
   output logic data_phase_start_q,
   output logic event_out_q
);

   // ----------------------------------------------------------------
   // set conditions
   // ----------------------------------------------------------------
   irq_src_t set_s;
   logic quick_hit;
   logic [NUM_SRC-1:0] set_vec;
   logic [NUM_SRC-1:0] flag_vec;
   logic [NUM_SRC-1:0] en_vec;
   logic [NUM_SRC-1:0] clr_vec;
   logic [NUM_SRC-1:0] ens_vec;
   logic [NUM_SRC-1:0] enc_vec;

   // picks the bus flag for the side that owns the transfer
   function automatic irq_src_t side_flag(input logic ctrl_side);
      irq_src_t f;
      f = '0;
      if (ctrl_side)
      begin
         f.controller_side_bus_flag = 1'b1;
      end
      else
      begin
         f.target_side_bus_flag = 1'b1;
      end
      return f;
   endfunction

   assign quick_hit = bus_evt.addr_acked && quick_cmd_enable;

   always_comb
   begin
      set_s = '0;
      if (quick_hit || bus_evt.byte_done)
      begin
         set_s = side_flag(bus_evt.ctrl_side);
      end
      set_s.data_ready_flag = bus_evt.data_ready;
      set_s.address_match_flag = bus_evt.address_match;
      set_s.stop_received_flag = bus_evt.stop_received;
      set_s.error_flag = bus_evt.error;
   end

   assign set_vec = set_s;
   assign clr_vec = flag_clear_wr.wr ? flag_clear_wr.data : '0;
   assign ens_vec = enable_set_wr.wr ? enable_set_wr.data : '0;
   assign enc_vec = enable_clear_wr.wr ? enable_clear_wr.data : '0;

   // ----------------------------------------------------------------
   // flag and enable bits, one cell per source
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < NUM_SRC; i++)
      begin : g_src
         irq_source_cell u_cell (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .soft_clr(iface_reset),
            .set_evt(set_vec[i]),
            .clr_flag(clr_vec[i]),
            .en_set(ens_vec[i]),
            .en_clr(enc_vec[i]),
            .flag_q(flag_vec[i]),
            .enable_q(en_vec[i])
         );
      end
   endgenerate

   assign irq_flag_reg = flag_vec;
   assign irq_enable_reg = en_vec;

   // ----------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || iface_reset)
      begin
         irq_request_q <= REQ_RST;
      end
      else
      begin
         irq_request_q <= |(flag_vec & en_vec);
      end
   end

   // ----------------------------------------------------------------
   // address phase outcome
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || iface_reset)
      begin
         data_phase_start_q <= 1'b0;
      end
      else
      begin
         // quick command skips the data phase and waits for software
         data_phase_start_q <= bus_evt.addr_acked && !quick_cmd_enable;
      end
   end

   // ----------------------------------------------------------------
   // dma requests; a new need wins over the withdrawing access
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || iface_reset || !dma_evt.target_tx_mode)
      begin
         dma_tx_request_q <= REQ_RST;
      end
      else if (dma_evt.tx_data_needed)
      begin
         dma_tx_request_q <= 1'b1;
      end
      else if (dma_evt.data_reg_written)
      begin
         dma_tx_request_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || iface_reset || !dma_evt.target_rx_mode)
      begin
         dma_rx_request_q <= REQ_RST;
      end
      else if (dma_evt.rx_data_received)
      begin
         dma_rx_request_q <= 1'b1;
      end
      else if (dma_evt.data_reg_read)
      begin
         dma_rx_request_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // event output: never pulses for any request condition
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      event_out_q <= EVENT_RST;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_quick_sets_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.addr_acked && quick_cmd_enable && !bus_evt.ctrl_side && !iface_reset)
      |=> irq_flag_reg.target_side_bus_flag)
      else $error("quick command did not set target side flag");

   a_quick_ctrl_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.addr_acked && quick_cmd_enable && bus_evt.ctrl_side && !iface_reset)
      |=> irq_flag_reg.controller_side_bus_flag)
      else $error("quick command did not set controller side flag");

   a_normal_no_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.addr_acked && !quick_cmd_enable && !bus_evt.byte_done && !bus_evt.ctrl_side
       && !irq_flag_reg.target_side_bus_flag)
      |=> !irq_flag_reg.target_side_bus_flag)
      else $error("address phase set bus flag with quick command off");

   a_byte_done_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.byte_done && !bus_evt.ctrl_side && !iface_reset)
      |=> irq_flag_reg.target_side_bus_flag)
      else $error("byte done did not set target side flag");

   a_ready_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.data_ready && !iface_reset) |=> irq_flag_reg.data_ready_flag)
      else $error("data ready flag not set");

   a_match_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.address_match && !iface_reset) |=> irq_flag_reg.address_match_flag)
      else $error("address match flag not set");

   a_error_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.error && !iface_reset) |=> irq_flag_reg.error_flag)
      else $error("error flag not set");

   a_enable_set_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (enable_set_wr.wr && enable_set_wr.data.data_ready_flag && !iface_reset)
      |=> irq_enable_reg.data_ready_flag)
      else $error("enable set did not enable data ready source");

   a_irq_low_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!(|(flag_vec & en_vec))) |=> !irq_request_q)
      else $error("interrupt request without an enabled flag");

   a_irq_held_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ((|(flag_vec & en_vec)) && !iface_reset) |=> irq_request_q)
      else $error("interrupt request dropped while flag and enable stand");

   a_reset_clears_all: assert property (@(posedge sys_clk) disable iff (sys_rst)
      iface_reset
      |=> (!irq_request_q && !dma_tx_request_q && !dma_rx_request_q
           && flag_vec == '0 && en_vec == '0))
      else $error("interface reset left state behind");

   a_dma_tx_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!dma_evt.target_tx_mode) |=> !dma_tx_request_q)
      else $error("transmit dma request outside target transmit mode");

   a_dma_rx_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!dma_evt.target_rx_mode) |=> !dma_rx_request_q)
      else $error("receive dma request outside target receive mode");

   a_dma_tx_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dma_tx_request_q && dma_evt.target_tx_mode && !dma_evt.data_reg_written
       && !iface_reset) |=> dma_tx_request_q)
      else $error("transmit dma request dropped without a data write");

   a_dma_rx_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dma_rx_request_q && dma_evt.target_rx_mode && !dma_evt.data_reg_read
       && !iface_reset) |=> dma_rx_request_q)
      else $error("receive dma request dropped without a data read");

   a_quick_no_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.addr_acked && !iface_reset)
      |=> data_phase_start_q == $past(!quick_cmd_enable))
      else $error("data phase start disagrees with quick command setting");

   a_source_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (bus_evt.stop_received && !iface_reset) |=> irq_flag_reg.stop_received_flag)
      else $error("stop received flag not set");

   a_flag_clear_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (flag_clear_wr.wr && flag_clear_wr.data.error_flag && !bus_evt.error)
      |=> !irq_flag_reg.error_flag)
      else $error("error flag not cleared by a one");

   a_flag_hold_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (irq_flag_reg.data_ready_flag && !iface_reset
       && !(flag_clear_wr.wr && flag_clear_wr.data.data_ready_flag))
      |=> irq_flag_reg.data_ready_flag)
      else $error("data ready flag dropped without a clear");

   a_enable_set_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (enable_set_wr.wr && enable_set_wr.data.address_match_flag && !iface_reset)
      |=> irq_enable_reg.address_match_flag)
      else $error("enable set did not enable source");

   a_enable_clear_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (enable_clear_wr.wr && enable_clear_wr.data.address_match_flag
       && !(enable_set_wr.wr && enable_set_wr.data.address_match_flag))
      |=> !irq_enable_reg.address_match_flag)
      else $error("enable clear did not disable source");

   a_enable_zero_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!enable_set_wr.wr && !enable_clear_wr.wr && !iface_reset) |=> $stable(irq_enable_reg))
      else $error("enables changed without a one written");

   a_irq_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!iface_reset) |=> irq_request_q == $past(|(flag_vec & en_vec)))
      else $error("interrupt request does not follow flags and enables");

   a_dma_tx_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dma_evt.target_tx_mode && dma_evt.tx_data_needed && !iface_reset)
      ##1 (dma_evt.target_tx_mode && !dma_evt.tx_data_needed && dma_evt.data_reg_written
           && !iface_reset)
      |-> dma_tx_request_q ##1 !dma_tx_request_q)
      else $error("transmit dma request not raised then withdrawn");

   a_dma_rx_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dma_evt.target_rx_mode && dma_evt.rx_data_received && !iface_reset)
      ##1 (dma_evt.target_rx_mode && !dma_evt.rx_data_received && dma_evt.data_reg_read
           && !iface_reset)
      |-> dma_rx_request_q ##1 !dma_rx_request_q)
      else $error("receive dma request not raised then withdrawn");

   a_no_event_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dma_evt.tx_data_needed || dma_evt.rx_data_received || bus_evt.data_ready)
      |=> !event_out_q [*2])
      else $error("event output pulsed");

endmodule

`default_nettype wire

// File: dv/bus_partner_model.sv
// far-side two-wire device: issues bus event pulses to the block
`timescale 1ns/10ps
`default_nettype none

module bus_partner_model
   import i2c_req_pkg::*;
(
   input wire logic sys_clk,
   output var bus_event_t bus_evt
);
   initial bus_evt = '0;

   // call just after a falling edge; pulse lasts one cycle, side stays a level
   task automatic send(input bus_event_t ev);
      bus_event_t idle;
      begin
         idle = '0;
         idle.ctrl_side = ev.ctrl_side;
         bus_evt = ev;
         @(negedge sys_clk);
         bus_evt = idle;
      end
   endtask
endmodule

`default_nettype wire

// File: dv/i2c_req_irq_test.sv
// testbench: request and interrupt logic, directed scenarios
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module i2c_req_irq_test
   import i2c_req_pkg::*;
;
   logic sys_clk, sys_rst, iface_reset, quick_cmd_enable;
   wire bus_event_t bus_evt;
   dma_event_t dma_evt;
   reg_write_t flag_clear_wr, enable_set_wr, enable_clear_wr;
   irq_src_t irq_flag_reg, irq_enable_reg;
   logic irq_request_q, dma_tx_request_q, dma_rx_request_q, data_phase_start_q, event_out_q;
   int n_fail, n_checks;

   i2c_req_irq i2c_req_irq_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .iface_reset(iface_reset),
      .quick_cmd_enable(quick_cmd_enable), .bus_evt(bus_evt), .dma_evt(dma_evt),
      .flag_clear_wr(flag_clear_wr), .enable_set_wr(enable_set_wr),
      .enable_clear_wr(enable_clear_wr), .irq_flag_reg(irq_flag_reg),
      .irq_enable_reg(irq_enable_reg), .irq_request_q(irq_request_q),
      .dma_tx_request_q(dma_tx_request_q), .dma_rx_request_q(dma_rx_request_q),
      .data_phase_start_q(data_phase_start_q), .event_out_q(event_out_q));
   bus_partner_model bus_partner_model_i (.sys_clk(sys_clk), .bus_evt(bus_evt));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // which: 0 flag clear, 1 enable set, 2 enable clear
   task automatic sw_write(input int which, input logic [5:0] bits);
      reg_write_t w;
      begin
         // idle cycle first, so back-to-back writes never retouch a strobe in one step
         step(1);
         w.wr = 1'b1;
         w.data = irq_src_t'(bits);
         if (which == 0)
            flag_clear_wr = w;
         else if (which == 1)
            enable_set_wr = w;
         else
            enable_clear_wr = w;
         step(1);
         flag_clear_wr = '0;
         enable_set_wr = '0;
         enable_clear_wr = '0;
      end
   endtask

   function automatic bus_event_t ev(input int idx, input logic side);
      bus_event_t e;
      begin
         e = '0;
         e[idx] = 1'b1;
         e.ctrl_side = side;
         ev = e;
      end
   endfunction

   task automatic dstep(input logic [5:0] v);
      dma_evt = dma_event_t'(v);
      step(1);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_enables;
      sw_write(1, 6'h15);
      `CHK(irq_enable_reg, 6'h15)
      sw_write(1, 6'h00);
      `CHK(irq_enable_reg, 6'h15)
      sw_write(1, 6'h2A);
      `CHK(irq_enable_reg, 6'h3F)
      sw_write(2, 6'h05);
      `CHK(irq_enable_reg, 6'h3A)
      sw_write(2, 6'h00);
      `CHK(irq_enable_reg, 6'h3A)
      sw_write(2, 6'h3F);
      `CHK(irq_enable_reg, 6'h00)
   endtask

   task automatic t_flags;
      for (int i = 0; i < 4; i++)
      begin
         bus_partner_model_i.send(ev(6 - i, 1'b0));
         `CHK(irq_flag_reg, 6'h01 << i)
         sw_write(0, 6'h00);
         `CHK(irq_flag_reg, 6'h01 << i)
         sw_write(0, 6'h01 << i);
         `CHK(irq_flag_reg, 6'h00)
         `CHK(irq_request_q, 1'b0)
      end
   endtask

   task automatic t_irq;
      sw_write(1, 6'h01);
      bus_partner_model_i.send(ev(6, 1'b0));
      step(1);
      `CHK(irq_request_q, 1'b1)
      step(5);
      `CHK(irq_request_q, 1'b1)
      sw_write(0, 6'h01);
      step(1);
      `CHK(irq_request_q, 1'b0)
      bus_partner_model_i.send(ev(6, 1'b0));
      sw_write(2, 6'h01);
      step(1);
      `CHK({irq_request_q, irq_flag_reg}, 7'h01)
      sw_write(1, 6'h01);
      step(1);
      `CHK(irq_request_q, 1'b1)
      iface_reset = 1'b1;
      step(1);
      iface_reset = 1'b0;
      `CHK({irq_request_q, irq_flag_reg, irq_enable_reg}, 13'h0000)
   endtask

   task automatic t_quick;
      quick_cmd_enable = 1'b1;
      bus_partner_model_i.send(ev(2, 1'b0));
      `CHK({data_phase_start_q, irq_flag_reg}, 7'h10)
      step(1);
      bus_partner_model_i.send(ev(4, 1'b0));
      `CHK(irq_flag_reg, 6'h14)
      sw_write(0, 6'h14);
      bus_partner_model_i.send(ev(2, 1'b1));
      `CHK({data_phase_start_q, irq_flag_reg}, 7'h20)
      sw_write(0, 6'h20);
      quick_cmd_enable = 1'b0;
      bus_partner_model_i.send(ev(2, 1'b0));
      `CHK({data_phase_start_q, irq_flag_reg}, 7'h40)
      step(1);
      `CHK(data_phase_start_q, 1'b0)
      bus_partner_model_i.send(ev(1, 1'b0));
      `CHK(irq_flag_reg, 6'h10)
   endtask

   task automatic t_dma;
      dstep(6'h28);
      dstep(6'h20);
      `CHK({dma_tx_request_q, event_out_q}, 2'b10)
      dstep(6'h22);
      `CHK(dma_tx_request_q, 1'b0)
      dstep(6'h28);
      `CHK(dma_tx_request_q, 1'b1)
      dstep(6'h22);
      `CHK(dma_tx_request_q, 1'b0)
      dstep(6'h14);
      dstep(6'h10);
      `CHK({dma_rx_request_q, event_out_q}, 2'b10)
      dstep(6'h11);
      `CHK(dma_rx_request_q, 1'b0)
      dstep(6'h14);
      `CHK(dma_rx_request_q, 1'b1)
      dstep(6'h11);
      `CHK(dma_rx_request_q, 1'b0)
      dstep(6'h18);
      dstep(6'h00);
      `CHK({dma_tx_request_q, event_out_q}, 2'b00)
   endtask

   initial
   begin
      repeat (2000) @(posedge sys_clk);
      n_fail++;
      report_and_stop;
   end

   initial
   begin
      n_fail = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      iface_reset = 1'b0;
      quick_cmd_enable = 1'b0;
      dma_evt = '0;
      flag_clear_wr = '0;
      enable_set_wr = '0;
      enable_clear_wr = '0;
      step(6);
      sys_rst = 1'b0;
      step(1);
      `CHK({irq_flag_reg, irq_enable_reg, irq_request_q, dma_tx_request_q}, 14'h0000)
      t_enables;
      t_flags;
      t_irq;
      t_quick;
      t_dma;
      report_and_stop;
   end
endmodule

`default_nettype wire
